// [logic/mit_map.vh]
// constants for the macro instruction transform block: apb offsets, field
// positions, command codes and reset values.
// assumes inclusion by bare name from the design files under logic/.
`ifndef MIT_MAP_VH
`define MIT_MAP_VH

// ==========================================================
// apb register byte offsets
`define MIT_OFS_CTRL      8'h00
`define MIT_OFS_STATUS    8'h04
`define MIT_OFS_HOLD      8'h08
`define MIT_OFS_ENC       8'h0c

// ==========================================================
// control register fields and reset value
`define MIT_CTRL_EN_BIT   0
`define MIT_CTRL_PAGE_LSB 8
`define MIT_CTRL_PAGE_MSB 15
`define MIT_CTRL_RESET    32'h0000_0001

// ==========================================================
// encode register: xor mask applied to the encoded upper micro word
`define MIT_ENC_RESET     16'h0000

// ==========================================================
// double-prime command field codes (5 bits)
`define MIT_CMD_NOP       5'h00
`define MIT_CMD_TMA       5'h01
`define MIT_CMD_TK        5'h02
`define MIT_CMD_TN        5'h03
`define MIT_CMD_TMAK      5'h04
`define MIT_CMD_GTMAK_J   5'h05
`define MIT_CMD_GTMAK_XT  5'h06

// ==========================================================
// fixed selector positions
`define MIT_KN_XT_POS     3'h7
`define MIT_ST_REF_POS    4'hb
`define MIT_PROT_POS      4'hf

`endif

// [logic/mit_hold_regs.v]
// capture registers for the macro instruction and its delta field.
// assumes macro-memory read data is valid in the cycle of the capture strobe.
`timescale 1ns/10ps

module mit_hold_regs #(
   parameter IW = 16,
   parameter DW = 8
) (
   input  wire          pclk,
   input  wire          presetn,
   input  wire          cap_instr,
   input  wire          cap_delta,
   input  wire [IW-1:0] rd_data,
   output reg  [IW-1:0] instr_hold_reg_q,
   output reg  [DW-1:0] delta_hold_reg_q
);

   // ==========================================================
   // hold registers
   // both load straight from macro memory; delta takes the low byte only
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         instr_hold_reg_q <= {IW{1'b0}};
         delta_hold_reg_q <= {DW{1'b0}};
      end else begin
         if (cap_instr) begin
            instr_hold_reg_q <= rd_data;
         end
         if (cap_delta) begin
            delta_hold_reg_q <= rd_data[DW-1:0];
         end
      end
   end

endmodule // mit_hold_regs

// [logic/mit_transform.v]
// macro instruction transform unit: decodes transform commands of the
// double-prime field, forms next micro address, loads k and n, encodes mir.
// assumes the microsequencer, mir and macro memory run on pclk and present
// one microinstruction per cycle in which cmd_valid is high.
// How it works
// RULE1: address transforms take the position from mir bits 28..31.
// RULE2: k and n transforms take the position from mir bits 29..31.
// RULE3: commands are recognised only from the double-prime command field.
// RULE4: address transform yields next micro pair address from selector.
// RULE5: k transform loads k from the k/n selector.
// RULE6: n transform loads n from the k/n selector.
// RULE7: combined command does address and k load with one position.
// RULE8: gated combined command captures read data, then combined transform.
// RULE9: gated decoded command captures read data into both hold registers.
// RULE10: decoded command picks address position 8..15 from the macro instruction.
// RULE11: decoded command always loads k from k/n position 7.
// RULE12: decoded command loads upper 16 mir bits with encoded micro command.
// RULE13: lower 16 mir bits still load normally from micro memory.
// RULE14: microprogram issues gated commands right after a macro read.
// RULE15: instruction hold register is 16 bits, loaded from macro read data.
// RULE16: delta hold register is 8 bits, the low byte of the word.
// RULE17: address selector is 8 bits wide with sixteen positions in page.
// RULE18: k/n selector is 8 bits wide with eight positions.
// RULE19: every transform completes within its single microinstruction cycle.
`timescale 1ns/10ps
`include "mit_map.vh"

module mit_transform #(
   parameter IW = 16,
   parameter DW = 8,
   parameter AW = 8
) (
   input  wire          pclk,
   input  wire          presetn,
   // apb slave
   input  wire          psel,
   input  wire          penable,
   input  wire          pwrite,
   input  wire [7:0]    paddr,
   input  wire [31:0]   pwdata,
   output wire          pready,
   output wire          pslverr,
   output reg  [31:0]   prdata,
   // microsequencer side
   input  wire          cmd_valid,
   input  wire [4:0]    cmd_dprime,
   input  wire [3:0]    mir_low_bits,
   input  wire [7:0]    s2_low,
   input  wire          int_req,
   input  wire          prot_viol,
   input  wire          indirect_mode,
   // macro memory read path
   input  wire [IW-1:0] macro_rd_data,
   // results to the processor
   output reg  [AW-1:0] next_addr_q,
   output reg  [7:0]    next_page_q,
   output reg           next_addr_load_q,
   output reg  [7:0]    k_value_q,
   output reg           k_load_q,
   output reg  [7:0]    n_value_q,
   output reg           n_load_q,
   output reg  [15:0]   mir_upper_q,
   output reg           mir_upper_load_q
);

   // ==========================================================
   // declarations
   reg  [31:0]   ctrl_q;
   reg  [15:0]   enc_mask_q;
   reg  [7:0]    cmd_count_q;
   wire          en;
   wire          c_tma;
   wire          c_tk;
   wire          c_tn;
   wire          c_tmak;
   wire          c_gj;
   wire          c_gxt;
   wire          do_addr;
   wire          do_k;
   wire          do_n;
   wire          cap_instr;
   wire          cap_delta;
   wire [IW-1:0] ixt_q;
   wire [DW-1:0] dlt_q;
   wire [IW-1:0] ixt_now;
   wire [DW-1:0] dlt_now;
   wire [3:0]    addr_pos;
   wire [2:0]    kn_pos;
   wire [7:0]    kn_sel;
   wire          apb_wr;
   wire          hit;

   // ==========================================================
   // functions
   // address selector, bit 0 of the printed pattern is our msb
   function [7:0] addr_sel;
      input [3:0]    pos;
      input [IW-1:0] ix;
      input [DW-1:0] dl;
      input [7:0]    s2;
      input          irq;
      input          pv;
      input          ind;
      reg            dz;
      reg            fz;
      reg            bc;
      begin
         dz = (dl == 8'h00);
         fz = (ix[15:12] == 4'h0);
         bc = (ix[11:10] == 2'b00) | ind;
         case (pos)
            4'h0: addr_sel = {7'b1111110, irq};
            4'h1: addr_sel = {5'b10111, dl[4:3], 1'b0};
            4'h2: addr_sel = {5'b11011, dl[2:0]};
            4'h3: addr_sel = {5'b00111, dl[2:0]};
            4'h4: addr_sel = {3'b111, dl[4:0]};
            4'h5: addr_sel = 8'h00;
            4'h6: addr_sel = {4'b1101, dl[7:4]};
            4'h7: addr_sel = s2;
            4'h8: addr_sel = {3'b110, dl[7:4], 1'b0};
            4'h9: addr_sel = {5'b10110, dl[7:5]};
            4'ha: addr_sel = {4'b1110, ix[3:0]};
            4'hb: addr_sel = {3'b100, ix[15:12], 1'b0};
            4'hc: addr_sel = {4'b1111, dl[7:4]};
            4'hd: addr_sel = {2'b01, fz, ix[11:8], dz};
            4'he: addr_sel = {5'b10100, bc, ix[9:8]};
            default: addr_sel = {6'b101110, pv, dz | pv};
         endcase
      end
   endfunction

   // k/n selector, eight positions
   function [7:0] kn_mux;
      input [2:0]    pos;
      input [IW-1:0] ix;
      input [DW-1:0] dl;
      input [7:0]    s2;
      begin
         case (pos)
            3'h0: kn_mux = dl;
            3'h1: kn_mux = ix[7:0];
            3'h2: kn_mux = ix[15:8];
            3'h3: kn_mux = {4'h0, ix[11:8]};
            3'h4: kn_mux = {4'h0, ix[3:0]};
            3'h5: kn_mux = {4'h0, dl[3:0]};
            3'h6: kn_mux = s2;
            default: kn_mux = {4'h0, ix[15:12]};
         endcase
      end
   endfunction

   // hardware decode of the macro instruction into an upper position
   function [3:0] xt_pos;
      input [IW-1:0] ix;
      input          pv;
      begin
         if (pv) begin
            xt_pos = `MIT_PROT_POS;
         end else if (ix[15:12] != 4'h0) begin
            xt_pos = `MIT_ST_REF_POS;
         end else begin
            xt_pos = {1'b1, ix[10:8]};
         end
      end
   endfunction

   // ==========================================================
   // command decode
   assign en     = ctrl_q[`MIT_CTRL_EN_BIT];
   // RULE3 double-prime field only
   assign c_tma  = en & cmd_valid & (cmd_dprime == `MIT_CMD_TMA);
   assign c_tk   = en & cmd_valid & (cmd_dprime == `MIT_CMD_TK);
   assign c_tn   = en & cmd_valid & (cmd_dprime == `MIT_CMD_TN);
   assign c_tmak = en & cmd_valid & (cmd_dprime == `MIT_CMD_TMAK);
   assign c_gj   = en & cmd_valid & (cmd_dprime == `MIT_CMD_GTMAK_J);
   assign c_gxt  = en & cmd_valid & (cmd_dprime == `MIT_CMD_GTMAK_XT);

   // RULE7 combined uses both paths
   assign do_addr = c_tma | c_tmak | c_gj | c_gxt;
   assign do_k    = c_tk | c_tmak | c_gj | c_gxt;
   assign do_n    = c_tn;

   // ==========================================================
   // capture of macro read data
   // RULE8 gated combined captures instruction
   // RULE9 decoded captures both
   // RULE14 data valid right after read
   assign cap_instr = c_gj | c_gxt;
   assign cap_delta = c_gxt;

   // RULE15 instruction hold
   // RULE16 delta hold
   mit_hold_regs #(
      .IW (IW),
      .DW (DW)
   ) u_hold (
      .pclk             (pclk),
      .presetn          (presetn),
      .cap_instr        (cap_instr),
      .cap_delta        (cap_delta),
      .rd_data          (macro_rd_data),
      .instr_hold_reg_q (ixt_q),
      .delta_hold_reg_q (dlt_q)
   );

   // RULE19 bypass so capture and transform share one cycle
   assign ixt_now = cap_instr ? macro_rd_data : ixt_q;
   assign dlt_now = cap_delta ? macro_rd_data[DW-1:0] : dlt_q;

   // ==========================================================
   // position selection
   // RULE1 four low mir bits
   // RULE10 decoded upper eight
   assign addr_pos = c_gxt ? xt_pos(ixt_now, prot_viol) : mir_low_bits;
   // RULE2 three low mir bits
   // RULE11 fixed position seven
   assign kn_pos   = c_gxt ? `MIT_KN_XT_POS : mir_low_bits[2:0];
   // RULE18 eight-way selector
   assign kn_sel   = kn_mux(kn_pos, ixt_now, dlt_now, s2_low);

   // ==========================================================
   // transform results, one-cycle load strobes
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         next_addr_q      <= {AW{1'b0}};
         next_page_q      <= 8'h00;
         next_addr_load_q <= 1'b0;
         k_value_q        <= 8'h00;
         k_load_q         <= 1'b0;
         n_value_q        <= 8'h00;
         n_load_q         <= 1'b0;
         mir_upper_q      <= 16'h0000;
         mir_upper_load_q <= 1'b0;
      end else begin
         next_addr_load_q <= do_addr;
         k_load_q         <= do_k;
         n_load_q         <= do_n;
         mir_upper_load_q <= c_gxt;
         // RULE4 next pair address
         // RULE17 address within page
         if (do_addr) begin
            next_addr_q <= addr_sel(addr_pos, ixt_now, dlt_now, s2_low, int_req, prot_viol, indirect_mode);
            next_page_q <= ctrl_q[`MIT_CTRL_PAGE_MSB:`MIT_CTRL_PAGE_LSB];
         end
         // RULE5 k load
         if (do_k) begin
            k_value_q <= kn_sel;
         end
         // RULE6 n load
         if (do_n) begin
            n_value_q <= kn_sel;
         end
         // RULE12 encode upper half
         // RULE13 lower half untouched
         if (c_gxt) begin
            mir_upper_q <= {ixt_now[15:12], 4'h0, ixt_now[11:8], ixt_now[3:0]} ^ enc_mask_q;
         end
      end
   end

   // ==========================================================
   // apb slave: zero wait states, unmapped offsets answer with pslverr
   assign pready  = 1'b1;
   assign hit     = (paddr == `MIT_OFS_CTRL) | (paddr == `MIT_OFS_STATUS) |
                    (paddr == `MIT_OFS_HOLD) | (paddr == `MIT_OFS_ENC);
   assign pslverr = psel & penable & ~hit;
   assign apb_wr  = psel & penable & pwrite;

   // writable control and encode mask; count of accepted commands for status
   always @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
         ctrl_q      <= `MIT_CTRL_RESET;
         enc_mask_q  <= `MIT_ENC_RESET;
         cmd_count_q <= 8'h00;
      end else begin
         if (apb_wr && paddr == `MIT_OFS_CTRL) begin
            ctrl_q <= {16'h0000, pwdata[15:8], 7'h00, pwdata[0]};
         end
         if (apb_wr && paddr == `MIT_OFS_ENC) begin
            enc_mask_q <= pwdata[15:0];
         end
         if (do_addr | do_k | do_n) begin
            cmd_count_q <= cmd_count_q + 8'h01; // wraps, diagnostic only
         end
      end
   end

   // read mux; unmapped and reserved bits read zero
   always @* begin
      case (paddr)
         `MIT_OFS_CTRL:   prdata = ctrl_q;
         `MIT_OFS_STATUS: prdata = {cmd_count_q, n_value_q, k_value_q, next_addr_q};
         `MIT_OFS_HOLD:   prdata = {8'h00, dlt_q, ixt_q};
         `MIT_OFS_ENC:    prdata = {16'h0000, enc_mask_q};
         default:         prdata = 32'h0000_0000;
      endcase
   end

endmodule // mit_transform

// [tb/mit_transform_assertions.sv]
// port checker for the transform block, bound after the module.
// assumes pclk rising edge and asynchronous active-low presetn.
`timescale 1ns/10ps
`include "mit_map.vh"

// ==========================================================
// checker
module mit_transform_assertions (
   input wire        pclk,
   input wire        presetn,
   input wire        psel,
   input wire        penable,
   input wire        pwrite,
   input wire [7:0]  paddr,
   input wire [31:0] pwdata,
   input wire        pready,
   input wire        pslverr,
   input wire        cmd_valid,
   input wire [4:0]  cmd_dprime,
   input wire [3:0]  mir_low_bits,
   input wire [7:0]  s2_low,
   input wire [15:0] macro_rd_data,
   input wire [7:0]  next_addr_q,
   input wire        next_addr_load_q,
   input wire [7:0]  k_value_q,
   input wire        k_load_q,
   input wire [7:0]  n_value_q,
   input wire        n_load_q,
   input wire        mir_upper_load_q
);
   reg        en_q;
   wire       go     = cmd_valid && en_q;
   wire [3:0] ix_top = macro_rd_data[15:12];
   wire       mapped = paddr == `MIT_OFS_CTRL || paddr == `MIT_OFS_STATUS || paddr == `MIT_OFS_HOLD ||
                       paddr == `MIT_OFS_ENC;
   // mirror of the enable bit, so refusals can be told apart from slips
   always @(posedge pclk or negedge presetn) begin
      if (!presetn)
         en_q <= 1'b1;
      else if (psel && penable && pwrite && pready && paddr == `MIT_OFS_CTRL)
         en_q <= pwdata[`MIT_CTRL_EN_BIT];
   end
   default clocking cb @(posedge pclk); endclocking
   default disable iff (!presetn);
   property p_refused;
      !(go && cmd_dprime >= `MIT_CMD_TMA && cmd_dprime <= `MIT_CMD_GTMAK_XT) |=>
         !next_addr_load_q && !k_load_q && !n_load_q && !mir_upper_load_q;
   endproperty
   a_refused: assert property (p_refused) else $error("pulse without accepted command");
   property p_addr;
      go && cmd_dprime == `MIT_CMD_TMA |=> next_addr_load_q && !k_load_q && !n_load_q && !mir_upper_load_q;
   endproperty
   a_addr: assert property (p_addr) else $error("address transform pulses wrong");
   property p_k;
      go && cmd_dprime == `MIT_CMD_TK |=> k_load_q && !next_addr_load_q && !n_load_q;
   endproperty
   a_k: assert property (p_k) else $error("k transform pulses wrong");
   property p_n;
      go && cmd_dprime == `MIT_CMD_TN |=> n_load_q && !k_load_q && !next_addr_load_q;
   endproperty
   a_n: assert property (p_n) else $error("n transform pulses wrong");
   property p_ak;
      go && (cmd_dprime == `MIT_CMD_TMAK || cmd_dprime == `MIT_CMD_GTMAK_J) |=>
         next_addr_load_q && k_load_q && !n_load_q && !mir_upper_load_q;
   endproperty
   a_ak: assert property (p_ak) else $error("combined transform pulses wrong");
   property p_dec;
      go && cmd_dprime == `MIT_CMD_GTMAK_XT |=> next_addr_load_q && k_load_q && mir_upper_load_q && !n_load_q;
   endproperty
   a_dec: assert property (p_dec) else $error("decoded command pulses wrong");
   property p_s2;
      go && cmd_dprime == `MIT_CMD_TMA && mir_low_bits == 4'h7 |=> next_addr_q == $past(s2_low);
   endproperty
   a_s2: assert property (p_s2) else $error("address position 7 not s2");
   property p_kn6;
      go && (cmd_dprime == `MIT_CMD_TK || cmd_dprime == `MIT_CMD_TN) && mir_low_bits[2:0] == 3'h6 |=>
         (k_load_q ? k_value_q : n_value_q) == $past(s2_low);
   endproperty
   a_kn6: assert property (p_kn6) else $error("k/n position 6 not s2");
   property p_k7;
      go && cmd_dprime == `MIT_CMD_GTMAK_XT |=> k_value_q == {4'h0, $past(ix_top)};
   endproperty
   a_k7: assert property (p_k7) else $error("decoded k not from position 7");
   property p_apb;
      psel && penable |-> pready && (pslverr == !mapped);
   endproperty
   a_apb: assert property (p_apb) else $error("apb answer wrong");
endmodule // mit_transform_assertions

bind mit_transform mit_transform_assertions u_mit_transform_assertions (.pclk, .presetn, .psel, .penable,
   .pwrite, .paddr, .pwdata, .pready, .pslverr, .cmd_valid, .cmd_dprime, .mir_low_bits, .s2_low,
   .macro_rd_data, .next_addr_q, .next_addr_load_q, .k_value_q, .k_load_q, .n_value_q, .n_load_q,
   .mir_upper_load_q);

// [tb/mit_useq_model.sv]
// microsequencer and macro read path model: one microinstruction per call.
// assumes the bench calls exec and idle from one process only.
`timescale 1ns/10ps
`include "mit_map.vh"

// ==========================================================
// model
module mit_useq_model (
   input  wire        pclk,
   output reg         cmd_valid,
   output reg  [4:0]  cmd_dprime,
   output reg  [3:0]  mir_low_bits,
   output reg  [7:0]  s2_low,
   output reg         int_req,
   output reg         prot_viol,
   output reg         indirect_mode,
   output reg  [15:0] macro_rd_data
);
   initial begin
      {cmd_valid, cmd_dprime, mir_low_bits, s2_low, int_req, prot_viol, indirect_mode} = 0;
      macro_rd_data = 16'h0000;
   end
   // drive one microinstruction just after an edge
   task exec(input [4:0] code, input [3:0] j, input [7:0] s2, input pv, input [15:0] word);
      begin
         @(posedge pclk);
         cmd_valid    <= 1'b1;
         cmd_dprime   <= code;
         mir_low_bits <= j;
         s2_low       <= s2;
         prot_viol    <= pv;
         // read word valid only after a read
         macro_rd_data <= (code == `MIT_CMD_GTMAK_J || code == `MIT_CMD_GTMAK_XT) ? word : ~macro_rd_data;
      end
   endtask
   // stale read data is inverted so nothing can latch it by luck
   task idle;
      begin
         @(posedge pclk);
         cmd_valid     <= 1'b0;
         macro_rd_data <= ~macro_rd_data;
         #1;
      end
   endtask
endmodule // mit_useq_model

// [tb/tb.sv]
// self-checking bench for the transform block over apb and the command port.
// assumes mit_map.vh on the include path and the checker bound alongside.
`timescale 1ns/10ps
`include "mit_map.vh"
`define CHK(a, b) begin num_checks = num_checks + 1; \
   if ((a) !== (b)) begin fail_count = fail_count + 1; $display("[FAIL] %0t got %h want %h", $time, a, b); end end

// ==========================================================
// bench
module tb;
   reg         pclk = 1'b0;
   reg         presetn = 1'b0;
   reg         psel = 1'b0;
   reg         penable = 1'b0;
   reg         pwrite = 1'b0;
   reg  [7:0]  paddr = 8'h00;
   reg  [31:0] pwdata = 32'h0;
   reg  [31:0] rd;
   reg         err;
   reg  [7:0]  a1;
   integer     fail_count = 0;
   integer     num_checks = 0;
   integer     p;
   wire        pready, pslverr, cmd_valid, int_req, prot_viol, indirect_mode;
   wire        next_addr_load_q, k_load_q, n_load_q, mir_upper_load_q;
   wire [31:0] prdata;
   wire [4:0]  cmd_dprime;
   wire [3:0]  mir_low_bits;
   wire [7:0]  s2_low, next_addr_q, next_page_q, k_value_q, n_value_q;
   wire [15:0] macro_rd_data, mir_upper_q;
   always #10 pclk = ~pclk;
   mit_useq_model u_mit_useq_model (.pclk(pclk), .cmd_valid(cmd_valid), .cmd_dprime(cmd_dprime),
      .mir_low_bits(mir_low_bits), .s2_low(s2_low), .int_req(int_req), .prot_viol(prot_viol),
      .indirect_mode(indirect_mode), .macro_rd_data(macro_rd_data));
   mit_transform u_mit_transform (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
      .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .pready(pready), .pslverr(pslverr), .prdata(prdata),
      .cmd_valid(cmd_valid), .cmd_dprime(cmd_dprime), .mir_low_bits(mir_low_bits), .s2_low(s2_low),
      .int_req(int_req), .prot_viol(prot_viol), .indirect_mode(indirect_mode), .macro_rd_data(macro_rd_data),
      .next_addr_q(next_addr_q), .next_page_q(next_page_q), .next_addr_load_q(next_addr_load_q),
      .k_value_q(k_value_q), .k_load_q(k_load_q), .n_value_q(n_value_q), .n_load_q(n_load_q),
      .mir_upper_q(mir_upper_q), .mir_upper_load_q(mir_upper_load_q));
   // expected k/n selector output per position
   function [7:0] kn(input [2:0] s, input [15:0] ix, input [7:0] dl, input [7:0] s2);
      case (s)
         3'd0: kn = dl;
         3'd1: kn = ix[7:0];
         3'd2: kn = ix[15:8];
         3'd3: kn = {4'h0, ix[11:8]};
         3'd4: kn = {4'h0, ix[3:0]};
         3'd5: kn = {4'h0, dl[3:0]};
         3'd6: kn = s2;
         default: kn = {4'h0, ix[15:12]};
      endcase
   endfunction
   task give_verdict;
      begin
         $display("checks %0d mismatches %0d", num_checks, fail_count);
         if (fail_count == 0 && num_checks > 0)
            $display("Run complete: PASS");
         else
            $display("Run complete: FAIL");
         $finish;
      end
   endtask
   // one apb transfer; read data taken at the completing edge
   task apb(input wr, input [7:0] a, input [31:0] d);
      integer n;
      begin
         @(posedge pclk);
         psel   <= 1'b1;
         pwrite <= wr;
         paddr  <= a;
         pwdata <= d;
         @(posedge pclk);
         penable <= 1'b1;
         for (n = 0; n < 16; n = n + 1) begin
            @(posedge pclk);
            if (pready === 1'b1) break;
         end
         rd  = prdata;
         err = pslverr;
         psel    <= 1'b0;
         penable <= 1'b0;
         if (n == 16) begin
            fail_count = fail_count + 1;
            give_verdict;
         end
      end
   endtask
   task t_regs;
      begin
         `CHK(next_addr_load_q, 1'b0)
         apb(0, `MIT_OFS_CTRL, 0); `CHK(rd, `MIT_CTRL_RESET)
         apb(0, `MIT_OFS_STATUS, 0); `CHK(rd, 32'h0)
         apb(1, `MIT_OFS_STATUS, 32'hffff_ffff); apb(0, `MIT_OFS_STATUS, 0); `CHK(rd, 32'h0)
         apb(1, `MIT_OFS_ENC, 32'h0000_0f0f); apb(0, `MIT_OFS_ENC, 0); `CHK(rd, 32'h0000_0f0f)
         apb(0, 8'h10, 0); `CHK(err, 1'b1) `CHK(rd, 32'h0)
         $display("test regs done");
      end
   endtask
   task t_dec;
      begin
         u_mit_useq_model.exec(`MIT_CMD_GTMAK_XT, 4'h0, 8'h00, 1'b0, 16'h3456);
         u_mit_useq_model.idle;
         `CHK({next_addr_load_q, k_load_q, mir_upper_load_q, n_load_q}, 4'he)
         `CHK(k_value_q, 8'h03)
         `CHK(mir_upper_q, 16'h3046 ^ 16'h0f0f)
         `CHK(next_addr_q, 8'h86)
         a1 = next_addr_q;
         u_mit_useq_model.exec(`MIT_CMD_TMA, 4'hb, 8'h00, 1'b0, 16'h0);
         u_mit_useq_model.idle;
         `CHK(next_addr_q, a1)
         apb(0, `MIT_OFS_HOLD, 0); `CHK(rd, 32'h0056_3456)
         u_mit_useq_model.exec(`MIT_CMD_GTMAK_XT, 4'h0, 8'h00, 1'b1, 16'h0123);
         u_mit_useq_model.idle;
         `CHK(next_addr_q, 8'hbb)
         a1 = next_addr_q;
         u_mit_useq_model.exec(`MIT_CMD_TMA, 4'hf, 8'h00, 1'b1, 16'h0);
         u_mit_useq_model.idle;
         `CHK(next_addr_q, a1)
         $display("test decoded done");
      end
   endtask
   task t_kn;
      begin
         u_mit_useq_model.exec(`MIT_CMD_GTMAK_J, 4'h5, 8'h00, 1'b0, 16'h9c35);
         u_mit_useq_model.idle;
         `CHK(next_addr_q, 8'h00)
         apb(0, `MIT_OFS_HOLD, 0); `CHK(rd, 32'h0023_9c35)
         for (p = 0; p < 8; p = p + 1) begin
            u_mit_useq_model.exec(`MIT_CMD_TK, {1'b1, p[2:0]}, 8'ha7, 1'b0, 16'h0);
            u_mit_useq_model.exec(`MIT_CMD_TN, {1'b0, p[2:0]}, 8'ha7, 1'b0, 16'h0);
            u_mit_useq_model.idle;
            `CHK(k_value_q, kn(p[2:0], 16'h9c35, 8'h23, 8'ha7))
            `CHK(n_value_q, kn(p[2:0], 16'h9c35, 8'h23, 8'ha7))
            `CHK({k_load_q, n_load_q}, 2'b01)
         end
         $display("test kn done");
      end
   endtask
   task t_addr;
      begin
         apb(1, `MIT_OFS_CTRL, 32'h0000_2a01);
         u_mit_useq_model.exec(`MIT_CMD_TMA, 4'h7, 8'hc3, 1'b0, 16'h0);
         u_mit_useq_model.idle;
         `CHK(next_addr_q, 8'hc3)
         `CHK(next_page_q, 8'h2a)
         u_mit_useq_model.exec(`MIT_CMD_TMAK, 4'h7, 8'h5e, 1'b0, 16'h0);
         u_mit_useq_model.idle;
         `CHK(next_addr_q, 8'h5e)
         `CHK(k_value_q, 8'h09)
         apb(1, `MIT_OFS_CTRL, 32'h0000_2a00);
         u_mit_useq_model.exec(`MIT_CMD_TMA, 4'h5, 8'h00, 1'b0, 16'h0);
         u_mit_useq_model.idle;
         `CHK({next_addr_load_q, next_addr_q}, 9'h05e)
         apb(1, `MIT_OFS_CTRL, 32'h0000_2a01);
         u_mit_useq_model.exec(5'h1f, 4'h5, 8'h00, 1'b0, 16'h0);
         u_mit_useq_model.idle;
         `CHK({next_addr_load_q, k_load_q, next_addr_q}, 10'h05e)
         $display("test addr done");
      end
   endtask
   initial begin
      repeat (5) @(posedge pclk);
      presetn <= 1'b1;
      t_regs;
      t_dec;
      t_kn;
      t_addr;
      give_verdict;
   end
endmodule // tb
